// file: common/madb_pkg.sv
// constants, operation codes and helpers shared by the add/and/bit datapath
package madb_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int BIT_W = 3;
    localparam int NIB_W = 4;
    // address of the timer count register inside the file space
    localparam logic [ADDR_W-1:0] TIMER_ADDR = 7'h01;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
    localparam logic DEST_WORK = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    typedef enum logic [2:0] {
        OP_NOP,
        OP_ADD_LITERAL_TO_WORK,
        OP_ADD_WORK_AND_FILE,
        OP_AND_LITERAL_WITH_WORK,
        OP_AND_WORK_WITH_FILE,
        OP_BIT_CLEAR_FILE,
        OP_BIT_SET_FILE,
        OP_BIT_TEST_SKIP_IF_CLEAR
    } madb_op_type;

    function automatic logic [DATA_W-1:0] madb_bit_mask(input logic [BIT_W-1:0] b);
        return ONE_BYTE << b;
    endfunction

    function automatic logic madb_is_add(input madb_op_type op);
        return (op == OP_ADD_LITERAL_TO_WORK) || (op == OP_ADD_WORK_AND_FILE);
    endfunction
endpackage

// file: common/madb_alu_if.sv
// operand and result bundle between the core and its arithmetic unit
`timescale 1ns/10ps
interface madb_alu_if;
    import madb_pkg::*;
    madb_op_type op;
    logic [DATA_W-1:0] work;
    logic [DATA_W-1:0] file;
    logic [DATA_W-1:0] lit;
    logic [BIT_W-1:0] bsel;
    logic [DATA_W-1:0] result;
    logic carry;
    logic digit_carry;
    logic zero;
    logic bit_val;

    modport core (
        output op, work, file, lit, bsel,
        input result, carry, digit_carry, zero, bit_val
    );
    modport alu (
        input op, work, file, lit, bsel,
        output result, carry, digit_carry, zero, bit_val
    );
endinterface

// file: rtl/madb_alu.sv
// combinational arithmetic and bit unit
`timescale 1ns/10ps
module madb_alu
    import madb_pkg::*;
(
    madb_alu_if.alu alu
);
    logic [DATA_W:0] sum;
    logic [NIB_W:0] nib_sum;
    logic [DATA_W-1:0] addend;

    always_comb
    begin
        addend = (alu.op == OP_ADD_LITERAL_TO_WORK) ? alu.lit : alu.file;
        sum = {1'b0, alu.work} + {1'b0, addend};
        nib_sum = {1'b0, alu.work[NIB_W-1:0]} + {1'b0, addend[NIB_W-1:0]};
        alu.carry = sum[DATA_W]; // [RULE13]
        alu.digit_carry = nib_sum[NIB_W]; // [RULE13]
        alu.bit_val = alu.file[alu.bsel];
        case (alu.op)
            OP_ADD_LITERAL_TO_WORK: alu.result = sum[DATA_W-1:0]; // [RULE4]
            OP_ADD_WORK_AND_FILE: alu.result = sum[DATA_W-1:0]; // [RULE7]
            OP_AND_LITERAL_WITH_WORK: alu.result = alu.work & alu.lit; // [RULE9]
            OP_AND_WORK_WITH_FILE: alu.result = alu.work & alu.file; // [RULE11]
            OP_BIT_CLEAR_FILE: alu.result = alu.file & ~madb_bit_mask(alu.bsel); // [RULE5]
            OP_BIT_SET_FILE: alu.result = alu.file | madb_bit_mask(alu.bsel); // [RULE6]
            default: alu.result = alu.file;
        endcase
        alu.zero = (alu.result == ZERO_BYTE); // [RULE12]
    end
endmodule

// file: rtl/madb_core.sv
// execution datapath for literal/register add and and, and the bit operations
// Functional notes
// [RULE1] A read-modify-write of an I/O port register takes its operand from the pins.
// [RULE2] A write to the timer count register clears its prescaler when assigned to it.
// [RULE3] A taken skip or program counter change costs two cycles, the second a no-op.
// [RULE4] Literal add puts work plus the 8-bit literal in work, updating C, DC and Z.
// [RULE5] Bit clear forces bit b of file register f to zero and touches no flag.
// [RULE6] Bit set forces bit b of file register f to one and touches no flag.
// [RULE7] Register add sums work and file f into the destination, updating C, DC and Z.
// [RULE8] Destination select 0 writes the work register, 1 writes back to file f.
// [RULE9] Literal and puts work and the literal in work, updating only Z.
// [RULE10] Bit test skips the next instruction when bit b of f is zero, no flags change.
// [RULE11] Register and puts work and file f into the destination, updating only Z.
// [RULE12] Zero flag is set when the 8-bit result is zero and cleared otherwise.
// [RULE13] Adds set carry from bit 7 and digit carry from bit 3, else clear them.
`timescale 1ns/10ps
module madb_core
    import madb_pkg::*;
#(
    parameter logic [ADDR_W-1:0] TIMER_ADDR_P = TIMER_ADDR
)
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // decoded instruction from fetch/decode
    input wire logic instr_valid_i,
    input wire madb_op_type op_i,
    input wire logic [ADDR_W-1:0] file_addr_i,
    input wire logic [BIT_W-1:0] bit_sel_i,
    input wire logic dest_i,
    input wire logic [DATA_W-1:0] literal_i,
    input wire logic pc_change_i,
    // file register space read side
    input wire logic [DATA_W-1:0] file_rdata_i,
    input wire logic [DATA_W-1:0] pin_rdata_i,
    input wire logic file_is_port_i,
    input wire logic prescaler_on_timer_i,
    // file register space write side
    output logic file_we_o,
    output logic [ADDR_W-1:0] file_waddr_o,
    output logic [DATA_W-1:0] file_wdata_o,
    output logic prescaler_clr_o,
    // core state
    output logic [DATA_W-1:0] work_o,
    output logic carry_o,
    output logic digit_carry_flag_o,
    output logic zero_o,
    output logic nop_cycle_o
);
    madb_alu_if alu_bus ();

    logic [DATA_W-1:0] work_q;
    logic carry_q;
    logic dc_q;
    logic zero_q;
    logic nop_q;
    logic file_we_q;
    logic [ADDR_W-1:0] file_waddr_q;
    logic [DATA_W-1:0] file_wdata_q;
    logic pscl_q;

    logic exec;
    logic [DATA_W-1:0] operand;
    logic writes_file;
    logic writes_work;
    logic is_add;
    logic is_and;
    logic skip_taken;

    madb_alu u_alu (
        .alu(alu_bus.alu)
    );

    // a port read sees the pins so an input pin pulled low is written back as zero
    assign operand = file_is_port_i ? pin_rdata_i : file_rdata_i; // [RULE1]

    assign alu_bus.op = op_i;
    assign alu_bus.work = work_q;
    assign alu_bus.file = operand;
    assign alu_bus.lit = literal_i;
    assign alu_bus.bsel = bit_sel_i;

    // the instruction fetched behind a taken skip is presented but dropped
    assign exec = instr_valid_i && !nop_q; // [RULE3]
    assign is_add = madb_is_add(op_i);
    assign is_and = (op_i == OP_AND_LITERAL_WITH_WORK) || (op_i == OP_AND_WORK_WITH_FILE);

    always_comb
    begin
        writes_file = 1'b0;
        writes_work = 1'b0;
        case (op_i)
            OP_ADD_LITERAL_TO_WORK: writes_work = 1'b1;
            OP_AND_LITERAL_WITH_WORK: writes_work = 1'b1;
            OP_ADD_WORK_AND_FILE, OP_AND_WORK_WITH_FILE:
            begin
                writes_file = (dest_i == DEST_FILE); // [RULE8]
                writes_work = (dest_i == DEST_WORK); // [RULE8]
            end
            OP_BIT_CLEAR_FILE, OP_BIT_SET_FILE: writes_file = 1'b1;
            default:
            begin
                writes_file = 1'b0;
                writes_work = 1'b0;
            end
        endcase
    end

    assign skip_taken = (op_i == OP_BIT_TEST_SKIP_IF_CLEAR) && !alu_bus.bit_val; // [RULE10]

    // work register
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            work_q <= ZERO_BYTE;
        else if (ce_i && exec && writes_work)
            work_q <= alu_bus.result; // [RULE4] [RULE9]
    end

    // status flags; bit ops and the skip test leave them alone
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            carry_q <= 1'b0;
            dc_q <= 1'b0;
            zero_q <= 1'b0;
        end
        else if (ce_i && exec)
        begin
            if (is_add)
            begin
                carry_q <= alu_bus.carry; // [RULE13] [RULE7]
                dc_q <= alu_bus.digit_carry; // [RULE13]
            end
            if (is_add || is_and)
                zero_q <= alu_bus.zero; // [RULE12] [RULE11]
        end
    end

    // file write port
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            file_we_q <= 1'b0;
            file_waddr_q <= '0;
            file_wdata_q <= ZERO_BYTE;
        end
        else if (ce_i)
        begin
            file_we_q <= exec && writes_file; // [RULE5] [RULE6] [RULE8]
            if (exec && writes_file)
            begin
                file_waddr_q <= file_addr_i;
                file_wdata_q <= alu_bus.result;
            end
        end
    end

    // prescaler clear pulse alongside the timer write
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            pscl_q <= 1'b0;
        else if (ce_i)
            pscl_q <= exec && writes_file && (file_addr_i == TIMER_ADDR_P)
                && prescaler_on_timer_i; // [RULE2]
    end

    // forced no-op second cycle
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            nop_q <= 1'b0;
        else if (ce_i)
            nop_q <= exec && (skip_taken || pc_change_i); // [RULE3] [RULE10]
    end

    assign work_o = work_q;
    assign carry_o = carry_q;
    assign digit_carry_flag_o = dc_q;
    assign zero_o = zero_q;
    assign nop_cycle_o = nop_q;
    assign file_we_o = file_we_q;
    assign file_waddr_o = file_waddr_q;
    assign file_wdata_o = file_wdata_q;
    assign prescaler_clr_o = pscl_q;

    // helper values for the checks below
    logic [DATA_W:0] chk_add_lit;
    logic [DATA_W-1:0] chk_bset_pin;
    logic chk_go;
    assign chk_add_lit = {1'b0, work_q} + {1'b0, literal_i};
    assign chk_bset_pin = pin_rdata_i | madb_bit_mask(bit_sel_i);
    assign chk_go = ce_i && exec;
    // nibble sum rebuilt from the operands, not taken from the arithmetic unit
    logic [NIB_W:0] chk_nib;
    assign chk_nib = {1'b0, work_q[NIB_W-1:0]}
        + {1'b0, (op_i == OP_ADD_LITERAL_TO_WORK) ? literal_i[NIB_W-1:0] : operand[NIB_W-1:0]};

    property p_port_pins;
        @(posedge clk_i) disable iff (!rst_b_i)
        chk_go && op_i == OP_BIT_SET_FILE && file_is_port_i
        |=> file_we_o && file_wdata_o == $past(chk_bset_pin);
    endproperty
    a_port_pins: assert property (p_port_pins) // [RULE1]
        else $error("port rmw did not use pin levels");

    property p_timer_clr;
        @(posedge clk_i) disable iff (!rst_b_i)
        prescaler_clr_o |-> file_we_o && file_waddr_o == TIMER_ADDR_P
            && $past(prescaler_on_timer_i);
    endproperty
    a_timer_clr: assert property (p_timer_clr) // [RULE2]
        else $error("prescaler clear without timer write");

    property p_timer_write;
        @(posedge clk_i) disable iff (!rst_b_i)
        chk_go && writes_file && file_addr_i == TIMER_ADDR_P && prescaler_on_timer_i
        |=> prescaler_clr_o;
    endproperty
    a_timer_write: assert property (p_timer_write) // [RULE2]
        else $error("timer write did not clear prescaler");

    property p_nop_cycle;
        @(posedge clk_i) disable iff (!rst_b_i)
        chk_go && pc_change_i |=> nop_cycle_o ##1 (!ce_i || (!file_we_o && $stable(work_o)));
    endproperty
    a_nop_cycle: assert property (p_nop_cycle) // [RULE3]
        else $error("second cycle after branch was not a no-op");

    property p_add_lit;
        @(posedge clk_i) disable iff (!rst_b_i)
        chk_go && op_i == OP_ADD_LITERAL_TO_WORK
        |=> work_o == $past(chk_add_lit[DATA_W-1:0]) && carry_o == $past(chk_add_lit[DATA_W]);
    endproperty
    a_add_lit: assert property (p_add_lit) // [RULE4] [RULE13]
        else $error("literal add result or carry wrong");

    property p_bit_flags;
        @(posedge clk_i) disable iff (!rst_b_i)
        chk_go && (op_i == OP_BIT_CLEAR_FILE || op_i == OP_BIT_TEST_SKIP_IF_CLEAR)
        |=> $stable(carry_o) && $stable(digit_carry_flag_o) && $stable(zero_o);
    endproperty
    a_bit_flags: assert property (p_bit_flags) // [RULE5] [RULE10]
        else $error("bit operation changed a flag");

    property p_bclr_bit;
        @(posedge clk_i) disable iff (!rst_b_i)
        chk_go && op_i == OP_BIT_CLEAR_FILE
        |=> file_we_o && file_wdata_o[$past(bit_sel_i)] == 1'b0;
    endproperty
    a_bclr_bit: assert property (p_bclr_bit) // [RULE5]
        else $error("bit clear left bit set");

    property p_dest_file;
        @(posedge clk_i) disable iff (!rst_b_i)
        chk_go && op_i == OP_ADD_WORK_AND_FILE && dest_i == DEST_FILE
        |=> file_we_o && file_waddr_o == $past(file_addr_i) && $stable(work_o);
    endproperty
    a_dest_file: assert property (p_dest_file) // [RULE7] [RULE8]
        else $error("add with file destination misrouted");

    property p_and_lit;
        @(posedge clk_i) disable iff (!rst_b_i)
        chk_go && op_i == OP_AND_LITERAL_WITH_WORK
        |=> $stable(carry_o) && $stable(digit_carry_flag_o) && zero_o == (work_o == ZERO_BYTE);
    endproperty
    a_and_lit: assert property (p_and_lit) // [RULE9] [RULE12]
        else $error("literal and flags wrong");

    property p_skip;
        @(posedge clk_i) disable iff (!rst_b_i)
        chk_go && skip_taken |=> nop_cycle_o && !file_we_o;
    endproperty
    a_skip: assert property (p_skip) // [RULE10]
        else $error("clear bit did not skip");

    property p_and_work;
        @(posedge clk_i) disable iff (!rst_b_i)
        chk_go && op_i == OP_AND_WORK_WITH_FILE && dest_i == DEST_WORK
        |=> !file_we_o && work_o == ($past(work_o) & $past(operand));
    endproperty
    a_and_work: assert property (p_and_work) // [RULE11] [RULE8]
        else $error("register and to work wrong");

    property p_add_dc;
        @(posedge clk_i) disable iff (!rst_b_i)
        chk_go && is_add |=> digit_carry_flag_o == $past(chk_nib[NIB_W]);
    endproperty
    a_add_dc: assert property (p_add_dc) // [RULE13]
        else $error("digit carry wrong after add");

    property p_bset_bit;
        @(posedge clk_i) disable iff (!rst_b_i)
        chk_go && op_i == OP_BIT_SET_FILE
        |=> file_we_o && file_wdata_o[$past(bit_sel_i)] == 1'b1 && $stable(zero_o) && $stable(carry_o);
    endproperty
    a_bset_bit: assert property (p_bset_bit) // [RULE6]
        else $error("bit set left bit clear or moved a flag");

    property p_add_work;
        @(posedge clk_i) disable iff (!rst_b_i)
        chk_go && op_i == OP_ADD_WORK_AND_FILE && dest_i == DEST_WORK
        |=> !file_we_o && work_o == $past(work_o) + $past(operand);
    endproperty
    a_add_work: assert property (p_add_work) // [RULE7] [RULE8]
        else $error("register add to work wrong");

    property p_and_file;
        @(posedge clk_i) disable iff (!rst_b_i)
        chk_go && op_i == OP_AND_WORK_WITH_FILE && dest_i == DEST_FILE
        |=> file_we_o && file_wdata_o == ($past(work_o) & $past(operand)) && $stable(work_o);
    endproperty
    a_and_file: assert property (p_and_file) // [RULE11] [RULE8]
        else $error("register and to file wrong");
endmodule

// file: bench/madb_file_model.sv
// file register space and pin levels seen by the datapath
`timescale 1ns/10ps
module madb_file_model
    import madb_pkg::*;
#(
    parameter logic [ADDR_W-1:0] PORT_ADDR = 7'h05
)
(
    // clock
    input wire logic clk_i,
    // read side
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] pin_lvl_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic [DATA_W-1:0] pin_o,
    output logic is_port_o,
    // write side
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] waddr_i,
    input wire logic [DATA_W-1:0] wdata_i
);
    logic [DATA_W-1:0] mem [2**ADDR_W];
    assign rdata_o = mem[addr_i];
    assign is_port_o = (addr_i == PORT_ADDR);
    // pins of a non-port address are meaningless: show the inverse so misuse shows
    assign pin_o = is_port_o ? pin_lvl_i : ~mem[addr_i];
    always @(posedge clk_i)
    begin
        if (we_i)
            mem[waddr_i] <= wdata_i;
    end
endmodule

// file: bench/tb.sv
// self-checking bench for the add/and/bit datapath
`timescale 1ns/10ps
module tb;
    import madb_pkg::*;
    localparam logic [ADDR_W-1:0] PORT_A = 7'h05;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic instr_valid_i = 1'b0;
    madb_op_type op_i = OP_NOP;
    logic [ADDR_W-1:0] file_addr_i = 7'h00;
    logic [BIT_W-1:0] bit_sel_i = 3'h0;
    logic dest_i = 1'b0;
    logic pc_change_i = 1'b0;
    logic ce_i = 1'b1;
    logic pre_i = 1'b0;
    logic [DATA_W-1:0] literal_i = 8'h00;
    logic [DATA_W-1:0] pin_lvl = 8'h00;
    logic [DATA_W-1:0] rdata, pins, wdata, work;
    logic [ADDR_W-1:0] waddr;
    logic is_port, we, pclr, carry, dcarry, zero, nop;
    logic [DATA_W-1:0] w = 8'h00;
    logic c = 1'b0;
    logic dc = 1'b0;
    logic z = 1'b0;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    always #10 clk_i = ~clk_i;

    madb_file_model #(.PORT_ADDR(PORT_A)) u_file (.clk_i(clk_i), .addr_i(file_addr_i),
        .pin_lvl_i(pin_lvl), .rdata_o(rdata), .pin_o(pins), .is_port_o(is_port),
        .we_i(we), .waddr_i(waddr), .wdata_i(wdata));

    madb_core #(.TIMER_ADDR_P(TIMER_ADDR)) DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
        .instr_valid_i(instr_valid_i), .op_i(op_i), .file_addr_i(file_addr_i),
        .bit_sel_i(bit_sel_i), .dest_i(dest_i), .literal_i(literal_i),
        .pc_change_i(pc_change_i), .file_rdata_i(rdata), .pin_rdata_i(pins),
        .file_is_port_i(is_port), .prescaler_on_timer_i(pre_i), .file_we_o(we),
        .file_waddr_o(waddr), .file_wdata_o(wdata), .prescaler_clr_o(pclr), .work_o(work),
        .carry_o(carry), .digit_carry_flag_o(dcarry), .zero_o(zero), .nop_cycle_o(nop));

    task automatic final_report();
        if (n_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    // one instruction with the file holding fv; port pins read as the inverse of the latch
    task automatic x(input madb_op_type op, input logic [ADDR_W-1:0] f,
        input logic [BIT_W-1:0] b, input logic d, input logic [DATA_W-1:0] k,
        input logic [DATA_W-1:0] fv, input logic pre, input logic pc);
        logic [DATA_W-1:0] src;
        logic [DATA_W-1:0] r;
        logic [8:0] s;
        logic wr;
        logic skip;
        u_file.mem[f] = fv;
        pin_lvl = ~fv;
        src = (f == PORT_A) ? ~fv : fv;
        op_i = op;
        file_addr_i = f;
        bit_sel_i = b;
        dest_i = d;
        literal_i = k;
        pre_i = pre;
        pc_change_i = pc;
        instr_valid_i = 1'b1;
        @(posedge clk_i);
        #1;
        // valid stays up between calls so it is never lowered and raised in one step
        wr = (op == OP_ADD_WORK_AND_FILE || op == OP_AND_WORK_WITH_FILE) ? d : 1'b0;
        skip = pc;
        r = w;
        if (op == OP_ADD_LITERAL_TO_WORK || op == OP_AND_LITERAL_WITH_WORK)
            src = k;
        case (op)
            OP_ADD_LITERAL_TO_WORK, OP_ADD_WORK_AND_FILE:
            begin
                s = {1'b0, w} + {1'b0, src};
                r = s[7:0];
                c = s[8];
                dc = ({1'b0, w[3:0]} + {1'b0, src[3:0]}) > 5'h0f;
                z = (r == 8'h00);
            end
            OP_AND_LITERAL_WITH_WORK, OP_AND_WORK_WITH_FILE:
            begin
                r = w & src;
                z = (r == 8'h00);
            end
            OP_BIT_CLEAR_FILE:
            begin
                r = src & ~(8'h01 << b);
                wr = 1'b1;
            end
            OP_BIT_SET_FILE:
            begin
                r = src | (8'h01 << b);
                wr = 1'b1;
            end
            OP_BIT_TEST_SKIP_IF_CLEAR: skip = skip | ~src[b];
            default: r = w;
        endcase
        if (!wr)
            w = r;
        chk(work === w, "work register");
        chk(carry === c && dcarry === dc, "carry flags");
        chk(zero === z, "zero flag");
        chk(we === wr, "write strobe");
        if (wr)
            chk(waddr === f && wdata === r, "write data");
        chk(pclr === (wr && f == TIMER_ADDR && pre), "prescaler clear");
        chk(nop === skip, "no-op cycle");
        if (skip)
        begin
            op_i = OP_ADD_LITERAL_TO_WORK;
            literal_i = 8'h55;
            instr_valid_i = 1'b1;
            @(posedge clk_i);
            #1;
            chk(work === w && nop === 1'b0 && we === 1'b0, "discarded slot");
        end
    endtask

    task automatic t_literal();
        x(OP_ADD_LITERAL_TO_WORK, 7'h00, 3'h0, 1'b0, 8'h0f, 8'h00, 1'b0, 1'b0);
        x(OP_ADD_LITERAL_TO_WORK, 7'h00, 3'h0, 1'b0, 8'h01, 8'h00, 1'b0, 1'b0);
        x(OP_ADD_LITERAL_TO_WORK, 7'h00, 3'h0, 1'b0, 8'hf0, 8'h00, 1'b0, 1'b0);
        x(OP_AND_LITERAL_WITH_WORK, 7'h00, 3'h0, 1'b0, 8'hff, 8'h00, 1'b0, 1'b0);
        x(OP_ADD_LITERAL_TO_WORK, 7'h00, 3'h0, 1'b0, 8'h3c, 8'h00, 1'b0, 1'b0);
        x(OP_AND_LITERAL_WITH_WORK, 7'h00, 3'h0, 1'b0, 8'hf0, 8'h00, 1'b0, 1'b0);
    endtask

    task automatic t_file_ops();
        x(OP_ADD_WORK_AND_FILE, 7'h0a, 3'h0, DEST_WORK, 8'h00, 8'h88, 1'b0, 1'b0);
        x(OP_ADD_WORK_AND_FILE, 7'h0a, 3'h0, DEST_FILE, 8'h00, 8'hc8, 1'b0, 1'b0);
        x(OP_AND_WORK_WITH_FILE, PORT_A, 3'h0, DEST_FILE, 8'h00, 8'h0f, 1'b0, 1'b0);
        x(OP_AND_WORK_WITH_FILE, 7'h0a, 3'h0, DEST_WORK, 8'h00, 8'h47, 1'b0, 1'b0);
    endtask

    task automatic t_timer();
        x(OP_BIT_SET_FILE, TIMER_ADDR, 3'h7, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0);
        x(OP_BIT_CLEAR_FILE, TIMER_ADDR, 3'h0, 1'b0, 8'h00, 8'hff, 1'b0, 1'b0);
        x(OP_ADD_WORK_AND_FILE, TIMER_ADDR, 3'h0, DEST_WORK, 8'h00, 8'h01, 1'b1, 1'b0);
        x(OP_AND_WORK_WITH_FILE, TIMER_ADDR, 3'h0, DEST_FILE, 8'h00, 8'h81, 1'b1, 1'b0);
    endtask

    // port latch and pins disagree on every bit, so a latch read shows at once
    task automatic t_port_bits();
        x(OP_BIT_CLEAR_FILE, PORT_A, 3'h7, 1'b0, 8'h00, 8'h0f, 1'b0, 1'b0);
        x(OP_BIT_SET_FILE, PORT_A, 3'h2, 1'b0, 8'h00, 8'h04, 1'b0, 1'b0);
        x(OP_BIT_TEST_SKIP_IF_CLEAR, PORT_A, 3'h0, 1'b0, 8'h00, 8'h01, 1'b0, 1'b0);
    endtask

    task automatic t_bits();
        x(OP_BIT_SET_FILE, 7'h7f, 3'h3, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
        x(OP_BIT_TEST_SKIP_IF_CLEAR, 7'h0a, 3'h3, 1'b0, 8'h00, 8'h08, 1'b0, 1'b0);
        x(OP_BIT_TEST_SKIP_IF_CLEAR, 7'h0a, 3'h3, 1'b0, 8'h00, 8'hf7, 1'b0, 1'b0);
    endtask

    task automatic t_branch();
        x(OP_AND_LITERAL_WITH_WORK, 7'h00, 3'h0, 1'b0, 8'hff, 8'h00, 1'b0, 1'b1);
    endtask

    // an instruction presented with the enable low must leave every output alone
    task automatic t_clock_enable();
        x(OP_ADD_LITERAL_TO_WORK, 7'h00, 3'h0, 1'b0, 8'h11, 8'h00, 1'b0, 1'b0);
        ce_i = 1'b0;
        literal_i = 8'h22;
        @(posedge clk_i);
        #1;
        chk(work === w && carry === c && zero === z && we === 1'b0 && nop === 1'b0, "frozen");
        ce_i = 1'b1;
        x(OP_NOP, 7'h00, 3'h0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
        x(OP_ADD_LITERAL_TO_WORK, 7'h00, 3'h0, 1'b0, 8'h22, 8'h00, 1'b0, 1'b0);
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles > 2000)
        begin
            n_errors++;
            final_report();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        chk(work === 8'h00 && we === 1'b0 && nop === 1'b0, "reset state");
        t_literal();
        t_file_ops();
        t_timer();
        t_port_bits();
        t_bits();
        t_branch();
        t_clock_enable();
        final_report();
    end
endmodule
